// ### logic/mii_pkg.sv
package mii_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLOCK_PERIOD_NS = 8;
	localparam int MGMT_HALF_NS = 200;
	localparam int MGMT_HALF_CYC = (MGMT_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam logic [7:0] MGMT_HALF_LAST = 8'(MGMT_HALF_CYC - 1);
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [4:0] A_CTRL = 5'h00;
	localparam logic [4:0] A_TXDATA = 5'h04;
	localparam logic [4:0] A_RXDATA = 5'h08;
	localparam logic [4:0] A_STATUS = 5'h0C;
	localparam logic [4:0] A_MASK = 5'h10;
	localparam logic [4:0] A_LINE = 5'h14;
	localparam logic [4:0] A_MGMT = 5'h18;
	localparam logic [7:0] CTRL_RESET = 8'h01;
	localparam int CTRL_MII_BIT = 0;
	localparam int CTRL_FDX_BIT = 1;
	localparam int TXD_LAST_BIT = 4;
	localparam int TXD_ERR_BIT = 5;
	localparam int TXD_BUSY_BIT = 8;
	localparam int RXD_ERR_BIT = 4;
	localparam int RXD_VALID_BIT = 5;
	localparam int MG_RD_BIT = 26;
	localparam int MG_BUSY_BIT = 31;
	// ----------------------------------------
	// Events
	// ----------------------------------------
	localparam int EV_TX_DONE = 0;
	localparam int EV_RX_NIB = 1;
	localparam int EV_RX_END = 2;
	localparam int EV_RX_ERR = 3;
	localparam int EV_COL = 4;
	localparam int EV_UNDERRUN = 5;
	localparam int EV_MGMT_DONE = 6;
	localparam int EV_W = 7;
	// ----------------------------------------
	// Synchroniser lanes
	// ----------------------------------------
	localparam int SY_TXC = 0;
	localparam int SY_RXC = 1;
	localparam int SY_DV = 2;
	localparam int SY_ER = 3;
	localparam int SY_COL = 4;
	localparam int SY_CRS = 5;
	localparam int SY_RXD = 6;
	localparam int SY_W = 10;
	// ----------------------------------------
	// Management frame
	// ----------------------------------------
	localparam logic [31:0] MGMT_PREAMBLE = 32'hFFFFFFFF;
	localparam logic [1:0] MGMT_START = 2'h1;
	localparam logic [1:0] MGMT_OP_RD = 2'h2;
	localparam logic [1:0] MGMT_OP_WR = 2'h1;
	localparam logic [1:0] MGMT_TA_WR = 2'h2;
	localparam logic [6:0] MGMT_TA_BIT = 7'h2E;
	localparam logic [6:0] MGMT_DATA_BIT = 7'h30;
	localparam logic [6:0] MGMT_LAST_BIT = 7'h3F;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_RUN = 1'b1} tx_state_t;
	typedef enum logic [1:0] {MG_IDLE = 2'b00, MG_LOW = 2'b01, MG_HIGH = 2'b10} mg_state_t;
	typedef struct packed {
		logic [4:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed {
		logic start;
		logic rd;
		logic [4:0] phy;
		logic [4:0] regad;
		logic [15:0] data;
	} mgmt_cmd_t;
	typedef struct packed {
		logic busy;
		logic done;
		logic [15:0] rdata;
	} mgmt_rsp_t;
endpackage : mii_pkg

// ### logic/mii_mgmt_engine.sv
`timescale 1ns/100ps
module mii_mgmt_engine (
	input wire logic clock,
	input wire logic reset_n,
	input wire mii_pkg::mgmt_cmd_t cmd,
	input wire logic mdio_in,
	output mii_pkg::mgmt_rsp_t rsp,
	output logic mdc,
	output logic mdo,
	output logic mdo_en
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic st;
		mii_pkg::mg_state_t mst;
		logic [7:0] div;
		logic [6:0] idx;
		logic [63:0] sh;
		logic rd;
		logic [15:0] rdata;
		logic mdc;
		logic mdo;
		logic oe;
		logic busy;
		logic done;
	} mg_t;
	mg_t s_ff;
	mg_t nxt_s;

	// ----------------------------------------
	// Frame sequencer
	// ----------------------------------------
	always_comb begin
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		nxt_s.s1 = mdio_in;
		nxt_s.s2 = s_ff.s1;
		nxt_s.s3 = s_ff.s2;
		if (s_ff.s2 == s_ff.s3) begin
			nxt_s.st = s_ff.s3;
		end
		case (s_ff.mst)
			mii_pkg::MG_IDLE: begin
				if (cmd.start) begin
					nxt_s.sh = {mii_pkg::MGMT_PREAMBLE, mii_pkg::MGMT_START,
						cmd.rd ? mii_pkg::MGMT_OP_RD : mii_pkg::MGMT_OP_WR, cmd.phy, cmd.regad,
						cmd.rd ? 2'h0 : mii_pkg::MGMT_TA_WR, cmd.rd ? 16'h0 : cmd.data};
					nxt_s.rd = cmd.rd;
					nxt_s.idx = 7'h0;
					nxt_s.div = 8'h0;
					nxt_s.busy = 1'b1;
					nxt_s.mdo = 1'b1;
					nxt_s.oe = 1'b1; // [R14]
					nxt_s.mst = mii_pkg::MG_LOW;
				end
			end
			mii_pkg::MG_LOW: begin
				nxt_s.div = s_ff.div + 8'h1;
				if (s_ff.div == mii_pkg::MGMT_HALF_LAST) begin
					nxt_s.div = 8'h0;
					nxt_s.mdc = 1'b1; // [R13]
					nxt_s.mst = mii_pkg::MG_HIGH;
				end
			end
			mii_pkg::MG_HIGH: begin
				nxt_s.div = s_ff.div + 8'h1;
				if (s_ff.div == mii_pkg::MGMT_HALF_LAST) begin
					// Sample late in the high phase, when the PHY's data has settled
					if (s_ff.rd && s_ff.idx >= mii_pkg::MGMT_DATA_BIT) begin
						nxt_s.rdata = {s_ff.rdata[14:0], s_ff.st};
					end
					nxt_s.div = 8'h0;
					nxt_s.mdc = 1'b0;
					nxt_s.idx = s_ff.idx + 7'h1;
					if (s_ff.idx == mii_pkg::MGMT_LAST_BIT) begin
						nxt_s.mst = mii_pkg::MG_IDLE;
						nxt_s.oe = 1'b0; // [R14]
						nxt_s.mdo = 1'b0;
						nxt_s.busy = 1'b0;
						nxt_s.done = 1'b1;
					end else begin
						nxt_s.sh = {s_ff.sh[62:0], 1'b0};
						nxt_s.mdo = s_ff.sh[62]; // [R13]
						nxt_s.oe = !s_ff.rd || (nxt_s.idx < mii_pkg::MGMT_TA_BIT); // [R14]
						nxt_s.mst = mii_pkg::MG_LOW;
					end
				end
			end
			default: nxt_s.mst = mii_pkg::MG_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign mdc = s_ff.mdc;
	assign mdo = s_ff.mdo;
	assign mdo_en = s_ff.oe;
	assign rsp = '{busy: s_ff.busy, done: s_ff.done, rdata: s_ff.rdata};

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence mdc_high_hold;
		s_ff.mdc [*8];
	endsequence
	AST_MDC_HIGH_HOLD: assert property ($rose(s_ff.mdc) |-> mdc_high_hold) // [R13]
		else $error("management clock high phase too short");
	AST_MDO_ON_LOW: assert property ($changed(s_ff.mdo) && s_ff.oe |-> !s_ff.mdc) // [R13]
		else $error("management data changed while clock high");
	AST_MDIO_IDLE_INPUT: assert property (s_ff.mst == mii_pkg::MG_IDLE |-> !s_ff.oe) // [R14]
		else $error("management line driven while idle");
	AST_MDIO_READ_RELEASE: assert property (s_ff.rd && s_ff.idx >= mii_pkg::MGMT_TA_BIT |-> !s_ff.oe) // [R14]
		else $error("management line driven during read reply");
endmodule : mii_mgmt_engine

// ### logic/mii_mac_pin_interface.sv
`timescale 1ns/100ps
// Functional notes
// [R01] Enable rises with first nibble, falls after last
// [R02] Transmit lines zero while enable low
// [R03] Serial mode uses bit 0; MII full nibble
// [R04] Transmit outputs timed to PHY transmit clock
// [R05] Error inject only with enable in MII
// [R06] Collision ignored in full duplex
// [R07] Receive inputs timed to PHY receive clock
// [R08] PHY frames valid over whole frame
// [R09] Nibbles accepted only while frame valid
// [R10] Serial receive uses bit 0 only
// [R11] Error with valid marks frame errored
// [R12] Medium idle only while carrier low; full duplex starts transmit with carrier high too
// [R13] Device drives management clock, data follows it
// [R14] Management line input unless device sending
// [R15] Transmit on clock edges, receive on edges
module mii_mac_pin_interface (
	input wire logic clock,
	input wire logic reset_n,
	input wire mii_pkg::reg_req_t reg_req,
	output logic [31:0] reg_rdata,
	output logic irq,
	input wire logic tx_nibble_clock,
	output logic tx_frame_enable,
	output logic [3:0] tx_nibble_lines,
	output logic tx_error_inject,
	input wire logic collision_sense,
	input wire logic carrier_sense,
	input wire logic rx_nibble_clock,
	input wire logic rx_frame_valid,
	input wire logic [3:0] rx_nibble_lines,
	input wire logic rx_error_flag,
	output logic mgmt_clock_line,
	input wire logic mgmt_data_in,
	output logic mgmt_data_out,
	output logic mgmt_data_oe
);
	typedef struct packed {
		logic [mii_pkg::SY_W-1:0] s1;
		logic [mii_pkg::SY_W-1:0] s2;
		logic [mii_pkg::SY_W-1:0] s3;
		logic [mii_pkg::SY_W-1:0] st;
		mii_pkg::tx_state_t tstate;
		logic [3:0] tcur;
		logic tlast;
		logic [1:0] tbit;
		logic hv;
		logic [3:0] hnib;
		logic hlast;
		logic herr;
		logic ten;
		logic [3:0] td;
		logic ter;
		logic [3:0] rasm;
		logic [1:0] rcnt;
		logic rdv_prev;
		logic rferr;
		logic rv;
		logic [3:0] rnib;
		logic rerr;
		logic [7:0] ctrl;
		logic [mii_pkg::EV_W-1:0] status;
		logic [mii_pkg::EV_W-1:0] mask;
		logic [31:0] rdata;
		logic irq;
		mii_pkg::mgmt_cmd_t mg;
	} state_t;
	state_t s_ff;
	state_t nxt_s;
	logic [mii_pkg::SY_W-1:0] sy_in;
	logic [mii_pkg::SY_W-1:0] agree;
	logic [mii_pkg::SY_W-1:0] st_new;
	logic [mii_pkg::SY_W-1:0] rise;
	logic [mii_pkg::SY_W-1:0] fall;
	logic [mii_pkg::EV_W-1:0] ev;
	logic [mii_pkg::EV_W-1:0] clr;
	logic mii;
	logic fdx;
	logic load;
	logic stop;
	logic push;
	logic [3:0] push_nib;
	mii_pkg::mgmt_rsp_t mg_rsp;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// A lane only moves once stages two and three agree, filtering metastable glitches
	assign sy_in = {rx_nibble_lines, carrier_sense, collision_sense, rx_error_flag,
		rx_frame_valid, rx_nibble_clock, tx_nibble_clock};
	assign agree = s_ff.s2 ~^ s_ff.s3;
	assign st_new = (agree & s_ff.s3) | (~agree & s_ff.st);
	assign rise = st_new & ~s_ff.st;
	assign fall = ~st_new & s_ff.st;
	assign mii = s_ff.ctrl[mii_pkg::CTRL_MII_BIT];
	assign fdx = s_ff.ctrl[mii_pkg::CTRL_FDX_BIT];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_s = s_ff;
		ev = '0;
		clr = '0;
		load = 1'b0;
		stop = 1'b0;
		push = 1'b0;
		push_nib = 4'h0;
		nxt_s.s1 = sy_in;
		nxt_s.s2 = s_ff.s1;
		nxt_s.s3 = s_ff.s2;
		nxt_s.st = st_new;
		nxt_s.rdata = 32'h0;
		nxt_s.mg.start = 1'b0;
		ev[mii_pkg::EV_MGMT_DONE] = mg_rsp.done;

		// Register port
		if (reg_req.wr) begin
			case (reg_req.addr)
				mii_pkg::A_CTRL: nxt_s.ctrl = reg_req.wdata[7:0];
				mii_pkg::A_TXDATA: begin
					// A write while the holding slot is full is dropped; poll the busy bit
					if (!s_ff.hv) begin
						nxt_s.hv = 1'b1;
						nxt_s.hnib = reg_req.wdata[3:0];
						nxt_s.hlast = reg_req.wdata[mii_pkg::TXD_LAST_BIT];
						nxt_s.herr = reg_req.wdata[mii_pkg::TXD_ERR_BIT];
					end
				end
				mii_pkg::A_STATUS: clr = reg_req.wdata[mii_pkg::EV_W-1:0];
				mii_pkg::A_MASK: nxt_s.mask = reg_req.wdata[mii_pkg::EV_W-1:0];
				mii_pkg::A_MGMT: begin
					if (!mg_rsp.busy) begin
						nxt_s.mg = '{start: 1'b1, rd: reg_req.wdata[mii_pkg::MG_RD_BIT],
							phy: reg_req.wdata[25:21], regad: reg_req.wdata[20:16],
							data: reg_req.wdata[15:0]};
					end
				end
				default: nxt_s.ctrl = s_ff.ctrl;
			endcase
		end
		if (reg_req.rd) begin
			case (reg_req.addr)
				mii_pkg::A_CTRL: nxt_s.rdata = {24'h0, s_ff.ctrl};
				mii_pkg::A_TXDATA: begin
					nxt_s.rdata[3:0] = s_ff.hnib;
					nxt_s.rdata[mii_pkg::TXD_LAST_BIT] = s_ff.hlast;
					nxt_s.rdata[mii_pkg::TXD_ERR_BIT] = s_ff.herr;
					nxt_s.rdata[mii_pkg::TXD_BUSY_BIT] = s_ff.hv;
				end
				mii_pkg::A_RXDATA: begin
					nxt_s.rdata[3:0] = s_ff.rnib;
					nxt_s.rdata[mii_pkg::RXD_ERR_BIT] = s_ff.rerr;
					nxt_s.rdata[mii_pkg::RXD_VALID_BIT] = s_ff.rv;
					nxt_s.rv = 1'b0;
				end
				mii_pkg::A_STATUS: nxt_s.rdata = {25'h0, s_ff.status};
				mii_pkg::A_MASK: nxt_s.rdata = {25'h0, s_ff.mask};
				mii_pkg::A_LINE: nxt_s.rdata = {28'h0, s_ff.ten, s_ff.st[mii_pkg::SY_DV],
					s_ff.st[mii_pkg::SY_COL], s_ff.st[mii_pkg::SY_CRS]};
				mii_pkg::A_MGMT: begin
					nxt_s.rdata[15:0] = mg_rsp.rdata;
					nxt_s.rdata[mii_pkg::MG_BUSY_BIT] = mg_rsp.busy;
				end
				default: nxt_s.rdata = 32'h0;
			endcase
		end

		// Transmit path, launched on the PHY clock's rising edge
		if (rise[mii_pkg::SY_TXC]) begin // [R04] [R15]
			case (s_ff.tstate)
				mii_pkg::TX_IDLE: load = s_ff.hv && (fdx || !s_ff.st[mii_pkg::SY_CRS]); // [R12]
				mii_pkg::TX_RUN: begin
					if (!mii && s_ff.tbit != 2'h3) begin
						nxt_s.tbit = s_ff.tbit + 2'h1;
						nxt_s.td = {3'h0, s_ff.tcur[nxt_s.tbit]}; // [R03]
					end else if (s_ff.tlast) begin
						stop = 1'b1;
						ev[mii_pkg::EV_TX_DONE] = 1'b1;
					end else if (s_ff.hv) begin
						load = 1'b1;
					end else begin
						stop = 1'b1;
						ev[mii_pkg::EV_UNDERRUN] = 1'b1;
					end
				end
				default: nxt_s.tstate = mii_pkg::TX_IDLE;
			endcase
		end
		if (load) begin
			nxt_s.tstate = mii_pkg::TX_RUN;
			nxt_s.hv = 1'b0;
			nxt_s.tcur = s_ff.hnib;
			nxt_s.tlast = s_ff.hlast;
			nxt_s.tbit = 2'h0;
			nxt_s.ten = 1'b1; // [R01]
			nxt_s.td = mii ? s_ff.hnib : {3'h0, s_ff.hnib[0]}; // [R03]
			nxt_s.ter = mii && s_ff.herr; // [R05]
		end
		if (stop) begin
			// Dropped one PHY clock after the final nibble went out
			nxt_s.tstate = mii_pkg::TX_IDLE;
			nxt_s.ten = 1'b0; // [R01]
			nxt_s.td = 4'h0; // [R02]
			nxt_s.ter = 1'b0; // [R05]
		end
		if (rise[mii_pkg::SY_COL] && !fdx && s_ff.tstate == mii_pkg::TX_RUN) begin // [R06]
			ev[mii_pkg::EV_COL] = 1'b1;
		end

		// Receive path, sampled mid-period on the falling edge
		if (fall[mii_pkg::SY_RXC]) begin // [R07] [R15]
			if (st_new[mii_pkg::SY_DV]) begin // [R09]
				if (st_new[mii_pkg::SY_ER]) begin // [R11]
					nxt_s.rferr = 1'b1;
					ev[mii_pkg::EV_RX_ERR] = !s_ff.rferr;
				end
				if (mii) begin
					push = 1'b1;
					push_nib = st_new[mii_pkg::SY_RXD+:4]; // [R09]
				end else begin
					nxt_s.rasm = {st_new[mii_pkg::SY_RXD], s_ff.rasm[3:1]}; // [R10]
					nxt_s.rcnt = s_ff.rcnt + 2'h1;
					push = s_ff.rcnt == 2'h3;
					push_nib = nxt_s.rasm;
				end
			end else if (s_ff.rdv_prev) begin
				ev[mii_pkg::EV_RX_END] = 1'b1;
				nxt_s.rferr = 1'b0; // [R11]
				nxt_s.rcnt = 2'h0;
			end
			nxt_s.rdv_prev = st_new[mii_pkg::SY_DV];
		end
		if (push) begin
			// New data beats a same-cycle read clear
			nxt_s.rv = 1'b1;
			nxt_s.rnib = push_nib;
			nxt_s.rerr = nxt_s.rferr;
			ev[mii_pkg::EV_RX_NIB] = 1'b1;
		end

		// Sticky events: a set wins over a same-cycle clear
		nxt_s.status = (s_ff.status & ~clr) | ev;
		nxt_s.irq = |(nxt_s.status & nxt_s.mask);
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_ff <= '0;
			s_ff.ctrl <= mii_pkg::CTRL_RESET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------
	// Management link
	// ----------------------------------------
	mii_mgmt_engine u_mgmt (
		.clock(clock),
		.reset_n(reset_n),
		.cmd(s_ff.mg),
		.mdio_in(mgmt_data_in),
		.rsp(mg_rsp),
		.mdc(mgmt_clock_line),
		.mdo(mgmt_data_out),
		.mdo_en(mgmt_data_oe)
	);

	assign reg_rdata = s_ff.rdata;
	assign irq = s_ff.irq;
	assign tx_frame_enable = s_ff.ten;
	assign tx_nibble_lines = s_ff.td;
	assign tx_error_inject = s_ff.ter;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence final_launch;
		rise[mii_pkg::SY_TXC] && s_ff.tstate == mii_pkg::TX_RUN && s_ff.tlast
			&& (mii || s_ff.tbit == 2'h3);
	endsequence
	AST_TX_ENABLE_DROP: assert property (final_launch |=> !s_ff.ten) // [R01]
		else $error("enable not dropped after final nibble");
	AST_TX_QUIET: assert property (!s_ff.ten |-> s_ff.td == 4'h0 && !s_ff.ter) // [R02]
		else $error("transmit lines active without enable");
	AST_TX_SERIAL_BIT0: assert property (!mii && s_ff.ten |-> s_ff.td[3:1] == 3'h0) // [R03]
		else $error("serial mode drove upper data bits");
	AST_TX_ERR_GATED: assert property (s_ff.ter |-> s_ff.ten && mii) // [R05]
		else $error("error inject outside MII frame");
	AST_TX_ON_EDGE: assert property ($changed(s_ff.ten) |-> $past(rise[mii_pkg::SY_TXC])) // [R15]
		else $error("enable moved away from a transmit clock edge");
	AST_RX_ONLY_VALID: assert property ($rose(s_ff.rv) |-> s_ff.st[mii_pkg::SY_DV]) // [R09]
		else $error("nibble taken without frame valid");
	AST_RX_SERIAL_FOUR: assert property ($rose(s_ff.rv) && !mii |-> s_ff.rcnt == 2'h0) // [R10]
		else $error("serial nibble pushed before four bits");
	AST_RX_ERR_MARK: assert property (fall[mii_pkg::SY_RXC] && st_new[mii_pkg::SY_DV]
		&& st_new[mii_pkg::SY_ER] |=> s_ff.rferr) // [R11]
		else $error("receive error not marked");
	AST_RX_ERR_IGNORED: assert property (s_ff.rferr |-> s_ff.rdv_prev) // [R11]
		else $error("frame error held outside a frame");
endmodule : mii_mac_pin_interface

// ### verif/mii_phy_model.sv
`timescale 1ns/100ps
module mii_phy_model (
	output logic tx_nibble_clock,
	output logic rx_nibble_clock,
	input wire logic tx_frame_enable,
	input wire logic [3:0] tx_nibble_lines,
	input wire logic tx_error_inject,
	output logic rx_frame_valid,
	output logic [3:0] rx_nibble_lines,
	output logic rx_error_flag,
	output logic carrier_sense
);
	logic [4:0] txq[$];
	logic crs_hold = 1'b0;
	// ----------
	// Clocks
	// ----------
	// PHY clocks run free; rx offset so the two domains never line up
	initial begin
		tx_nibble_clock = 1'b0;
		forever #80 tx_nibble_clock = ~tx_nibble_clock;
	end
	initial begin
		rx_nibble_clock = 1'b0;
		#37;
		forever #80 rx_nibble_clock = ~rx_nibble_clock;
	end
	initial begin
		rx_frame_valid = 1'b0;
		rx_nibble_lines = 4'hA;
		rx_error_flag = 1'b0;
	end
	// Own transmit counts as a busy medium too
	assign carrier_sense = crs_hold | rx_frame_valid | tx_frame_enable;
	// ----------
	// Transmit capture
	// ----------
	// Error kept beside the nibble instead of coding symbols
	always @(posedge tx_nibble_clock) begin
		if (tx_frame_enable) begin
			txq.push_back({tx_error_inject, tx_nibble_lines});
		end
	end
	task automatic hold_carrier(input logic v);
		crs_hold = v;
	endtask : hold_carrier
	// ----------
	// Receive drive
	// ----------
	task automatic rx_unit(input logic [3:0] d, input logic er);
		@(posedge rx_nibble_clock);
		rx_frame_valid <= 1'b1;
		rx_nibble_lines <= d;
		rx_error_flag <= er;
	endtask : rx_unit
	// Lines change as valid drops, so stale data cannot pass
	task automatic rx_stop(input logic er);
		@(posedge rx_nibble_clock);
		rx_frame_valid <= 1'b0;
		rx_nibble_lines <= ~rx_nibble_lines;
		rx_error_flag <= er;
	endtask : rx_stop
endmodule : mii_phy_model

// ### verif/test_mii_mac_pin_interface.sv
`timescale 1ns/100ps
module test_mii_mac_pin_interface;
	logic clock;
	logic reset_n;
	mii_pkg::reg_req_t reg_req;
	logic [31:0] reg_rdata;
	logic irq;
	logic tx_nibble_clock, rx_nibble_clock, tx_frame_enable, tx_error_inject;
	logic [3:0] tx_nibble_lines, rx_nibble_lines, d;
	logic collision_sense, carrier_sense, rx_frame_valid, rx_error_flag;
	logic mgmt_clock_line, mgmt_data_out, mgmt_data_oe, mgmt_in;
	logic [31:0] q;
	logic [31:0] seed = 32'h0D8B;
	logic [63:0] mg_bits;
	logic [4:0] exp_q[$];
	int failures = 0;
	int n_compared = 0;
	int mg_cnt, mg_oe;
	logic mg_drive = 1'b1;
	logic [15:0] mg_reply;
	// Released line follows the PHY reply, else idles high on its pull-up
	assign mgmt_in = mgmt_data_oe ? mgmt_data_out : mg_drive;
	mii_mac_pin_interface u_mii_mac_pin_interface (
		.clock(clock), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.irq(irq), .tx_nibble_clock(tx_nibble_clock), .tx_frame_enable(tx_frame_enable),
		.tx_nibble_lines(tx_nibble_lines), .tx_error_inject(tx_error_inject),
		.collision_sense(collision_sense), .carrier_sense(carrier_sense),
		.rx_nibble_clock(rx_nibble_clock), .rx_frame_valid(rx_frame_valid),
		.rx_nibble_lines(rx_nibble_lines), .rx_error_flag(rx_error_flag),
		.mgmt_clock_line(mgmt_clock_line), .mgmt_data_in(mgmt_in),
		.mgmt_data_out(mgmt_data_out), .mgmt_data_oe(mgmt_data_oe));
	mii_phy_model u_mii_phy_model (
		.tx_nibble_clock(tx_nibble_clock), .rx_nibble_clock(rx_nibble_clock),
		.tx_frame_enable(tx_frame_enable), .tx_nibble_lines(tx_nibble_lines),
		.tx_error_inject(tx_error_inject), .rx_frame_valid(rx_frame_valid),
		.rx_nibble_lines(rx_nibble_lines), .rx_error_flag(rx_error_flag),
		.carrier_sense(carrier_sense));
	// ----------
	// Helpers
	// ----------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic [4:0] a, input logic [31:0] wd, input logic w,
			output logic [31:0] rd);
		reg_req <= '{addr: a, wdata: wd, wr: w, rd: !w};
		@(posedge clock);
		reg_req <= '0;
		#1 rd = reg_rdata;
		@(posedge clock);
	endtask : bus
	task automatic wait_bit(input logic [4:0] a, input int b, input logic v);
		for (int i = 0; i < 2000; i++) begin
			bus(a, 32'h0, 1'b0, q);
			if (q[b] === v) return;
		end
		failures++;
	endtask : wait_bit
	task automatic rx_wait(input int n);
		repeat (n) @(negedge rx_nibble_clock);
		repeat (6) @(posedge clock);
	endtask : rx_wait
	task automatic tx_frame(input int n, input logic mii, input logic crs);
		logic [3:0] t;
		logic e;
		if (crs) u_mii_phy_model.hold_carrier(1'b1);
		for (int i = 0; i < n; i++) begin
			t = 4'(rnd());
			e = (i == 1);
			wait_bit(mii_pkg::A_TXDATA, mii_pkg::TXD_BUSY_BIT, 1'b0);
			bus(mii_pkg::A_TXDATA, {26'h0, e, i == n - 1, t}, 1'b1, q);
			// Collision only once the frame is running, so half duplex must flag it
			if (i == 2) collision_sense <= 1'b1;
			if (mii) exp_q.push_back({e, t});
			else for (int k = 0; k < 4; k++) exp_q.push_back({4'h0, t[k]});
			if (i == 0 && crs) begin
				repeat (60) @(posedge clock);
				chk(tx_frame_enable, 1'b0);
				bus(mii_pkg::A_LINE, 32'h0, 1'b0, q);
				chk(q, 32'h1);
				u_mii_phy_model.hold_carrier(1'b0);
			end
		end
		wait_bit(mii_pkg::A_STATUS, mii_pkg::EV_TX_DONE, 1'b1);
		chk(tx_frame_enable, 1'b0);
		chk(u_mii_phy_model.txq.size(), exp_q.size());
		foreach (exp_q[j]) chk(u_mii_phy_model.txq[j], exp_q[j]);
		exp_q.delete();
		u_mii_phy_model.txq.delete();
		bus(mii_pkg::A_STATUS, 32'h1, 1'b1, q);
		collision_sense <= 1'b0;
	endtask : tx_frame
	always @(posedge mgmt_clock_line) begin
		mg_bits <= {mg_bits[62:0], mgmt_in};
		mg_cnt <= mg_cnt + 1;
		mg_oe <= mg_oe + int'(mgmt_data_oe);
	end
	// PHY moves its reply bit after the clock falls; back to pull-up level after
	always @(negedge mgmt_clock_line) begin
		mg_drive <= (mg_cnt >= 48 && mg_cnt < 64) ? mg_reply[63 - mg_cnt] : 1'b1;
	end
	task automatic mgmt(input logic rd, input int oe_edges);
		logic [4:0] p;
		logic [4:0] r;
		logic [15:0] v;
		p = 5'(rnd());
		r = 5'(rnd());
		v = 16'(rnd());
		mg_reply = v;
		mg_cnt = 0;
		mg_oe = 0;
		bus(mii_pkg::A_MGMT, {5'h0, rd, p, r, v}, 1'b1, q);
		repeat (4) @(posedge clock);
		wait_bit(mii_pkg::A_MGMT, mii_pkg::MG_BUSY_BIT, 1'b0);
		// Write runs first and leaves the reply word at its reset value
		chk(q[15:0], rd ? v : 16'h0);
		chk(mg_cnt, 64);
		chk(mg_oe, oe_edges);
		chk(mg_bits, {32'hFFFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, p, r, 2'b10 | {1'b0, rd}, v});
		chk(mgmt_data_oe, 1'b0);
		bus(mii_pkg::A_STATUS, 32'h0, 1'b0, q);
		chk(q[mii_pkg::EV_MGMT_DONE], 1'b1);
		bus(mii_pkg::A_STATUS, 32'h40, 1'b1, q);
	endtask : mgmt
	task automatic finish_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	// ----------
	// Sequence
	// ----------
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		#400000;
		failures++;
		finish_test();
	end
	initial begin
		reset_n = 1'b0;
		reg_req = '0;
		collision_sense = 1'b0;
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		repeat (4) @(posedge clock);
		chk(mgmt_data_oe, 1'b0);
		bus(mii_pkg::A_CTRL, 32'h0, 1'b0, q);
		chk(q, 32'(mii_pkg::CTRL_RESET));
		bus(5'h1C, 32'h0, 1'b0, q);
		chk(q, 32'h0);
		bus(mii_pkg::A_MASK, 32'h10, 1'b1, q);
		tx_frame(6, 1'b1, 1'b1);
		bus(mii_pkg::A_STATUS, 32'h0, 1'b0, q);
		chk(q[4], 1'b1);
		chk(irq, 1'b1);
		bus(mii_pkg::A_STATUS, 32'h7F, 1'b1, q);
		bus(mii_pkg::A_STATUS, 32'h0, 1'b0, q);
		chk(q, 32'h0);
		chk(irq, 1'b0);
		bus(mii_pkg::A_CTRL, 32'h3, 1'b1, q);
		tx_frame(3, 1'b1, 1'b0);
		bus(mii_pkg::A_STATUS, 32'h0, 1'b0, q);
		chk(q[4], 1'b0);
		// Single non-last nibble and no refill: the frame must be cut short
		bus(mii_pkg::A_TXDATA, 32'h5, 1'b1, q);
		wait_bit(mii_pkg::A_STATUS, mii_pkg::EV_UNDERRUN, 1'b1);
		chk(tx_frame_enable, 1'b0);
		chk(u_mii_phy_model.txq.size(), 1);
		chk(u_mii_phy_model.txq[0], 5'h05);
		u_mii_phy_model.txq.delete();
		bus(mii_pkg::A_STATUS, 32'h20, 1'b1, q);
		bus(mii_pkg::A_CTRL, 32'h0, 1'b1, q);
		tx_frame(2, 1'b0, 1'b0);
		bus(mii_pkg::A_CTRL, 32'h1, 1'b1, q);
		for (int i = 0; i < 4; i++) begin
			d = 4'(rnd());
			u_mii_phy_model.rx_unit(d, i == 2);
			rx_wait(1);
			bus(mii_pkg::A_RXDATA, 32'h0, 1'b0, q);
			chk(q, {26'h0, 1'b1, i >= 2, d});
		end
		u_mii_phy_model.rx_stop(1'b1);
		rx_wait(2);
		bus(mii_pkg::A_STATUS, 32'h0, 1'b0, q);
		chk(q[3:1], 3'h7);
		bus(mii_pkg::A_STATUS, 32'hE, 1'b1, q);
		bus(mii_pkg::A_RXDATA, 32'h0, 1'b0, q);
		rx_wait(3);
		bus(mii_pkg::A_STATUS, 32'h0, 1'b0, q);
		chk(q[3:1], 3'h0);
		bus(mii_pkg::A_RXDATA, 32'h0, 1'b0, q);
		chk(q[5], 1'b0);
		bus(mii_pkg::A_CTRL, 32'h0, 1'b1, q);
		d = 4'(rnd());
		for (int k = 0; k < 4; k++) u_mii_phy_model.rx_unit({3'(rnd()), d[k]}, 1'b0);
		u_mii_phy_model.rx_stop(1'b0);
		rx_wait(2);
		bus(mii_pkg::A_RXDATA, 32'h0, 1'b0, q);
		chk(q, {26'h0, 2'b10, d});
		mgmt(1'b0, 64);
		mgmt(1'b1, 46);
		finish_test();
	end
endmodule : test_mii_mac_pin_interface
